// >>> common/vim_pkg.sv
// vectored interrupt map: shared constants and carrier types
// assumes one system clock and a processor core that fetches vectors
package vim_pkg;

   // ----------------------------------------
   // map geometry
   // ----------------------------------------
   localparam int NUM_PRIO = 25;
   localparam int VEC_W = 24;
   localparam int PRIO_W = 5;

   // ----------------------------------------
   // fixed vectors
   // ----------------------------------------
   localparam logic [VEC_W-1:0] RESET_VEC = 24'h008000;
   localparam logic [VEC_W-1:0] TRAP_VEC = 24'h008004;
   localparam logic [VEC_W-1:0] PRIO0_VEC = 24'h008008;
   localparam logic [VEC_W-1:0] VEC_STEP = 24'h000004;

   // ----------------------------------------
   // priority numbers of the sources
   // ----------------------------------------
   localparam int P_TOP_PIN = 0;
   localparam int P_AUTO_WAKE = 1;
   localparam int P_CLK_CTRL = 2;
   localparam int P_PORT_A = 3;
   localparam int P_SPI = 10;
   localparam int P_TIM1_UPD = 11;
   localparam int P_TIM1_CC = 12;
   localparam int P_TIM2_UPD = 13;
   localparam int P_TIM2_CC = 14;
   localparam int P_TIM3_UPD = 15;
   localparam int P_TIM3_CC = 16;
   localparam int P_I2C = 19;
   localparam int P_LIN_TX = 20;
   localparam int P_LIN_RX = 21;
   localparam int P_ADC = 22;
   localparam int P_TIM4_UPD = 23;
   localparam int P_DATA_MEM = 24;

   // reserved slots 8, 9, 17, 18 never carry a request
   localparam logic [NUM_PRIO-1:0] LIVE_MASK = 25'h1f9fcff;
   // slots able to end halt: 1, 3..7, 10, 19
   localparam logic [NUM_PRIO-1:0] WAKE_MASK = 25'h00804fa;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic top_pin;
      logic auto_wake;
      logic clk_ctrl;
      logic [4:0] port_ae;
      logic spi_eot;
      logic tim1_upd;
      logic tim1_cc;
      logic tim2_upd;
      logic tim2_cc;
      logic tim3_upd;
      logic tim3_cc;
      logic i2c;
      logic lin_tx;
      logic lin_rx;
      logic adc_eoc;
      logic tim4_upd;
      logic mem_done;
      logic mem_prot;
   } irq_src_t;

   typedef struct packed {
      logic valid;
      logic [PRIO_W-1:0] prio;
      logic [VEC_W-1:0] addr;
   } vec_req_t;

   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_RUN = 3'b010,
      ST_HALT = 3'b100
   } vim_state_t;

endpackage

// >>> logic/vectored_interrupt_map.sv
// vectored interrupt map: picks the pending source, forms its vector, wakes from halt
// assumes request levels synchronous to clk_i, held until the core serves them
`timescale 1ns/100ps
module vectored_interrupt_map (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // sources and core handshake
   input vim_pkg::irq_src_t src_i,
   input wire logic trap_i,
   input wire logic halt_req_i,
   input wire logic fetch_ack_i,
   // to the core
   output vim_pkg::vec_req_t req_o,
   output logic trap_pend_o,
   output logic halted_o,
   output logic wake_o
);
   import vim_pkg::*;

   // ----------------------------------------
   // source to slot mapping
   // ----------------------------------------
   function automatic logic [NUM_PRIO-1:0] map_slots(input irq_src_t s);
      logic [NUM_PRIO-1:0] v;
      v = '0;
      v[P_TOP_PIN] = s.top_pin;
      v[P_AUTO_WAKE] = s.auto_wake;
      v[P_CLK_CTRL] = s.clk_ctrl;
      for (int i = 0; i < 5; i++) begin
         v[P_PORT_A+i] = s.port_ae[i];
      end
      v[P_SPI] = s.spi_eot;
      v[P_TIM1_UPD] = s.tim1_upd;
      v[P_TIM1_CC] = s.tim1_cc;
      v[P_TIM2_UPD] = s.tim2_upd;
      v[P_TIM2_CC] = s.tim2_cc;
      v[P_TIM3_UPD] = s.tim3_upd;
      v[P_TIM3_CC] = s.tim3_cc;
      v[P_I2C] = s.i2c;
      v[P_LIN_TX] = s.lin_tx;
      v[P_LIN_RX] = s.lin_rx;
      v[P_ADC] = s.adc_eoc;
      v[P_TIM4_UPD] = s.tim4_upd;
      v[P_DATA_MEM] = s.mem_done | s.mem_prot;
      return v & LIVE_MASK;
   endfunction

   // vector address is linear in the priority number, reserved slots included
   function automatic logic [VEC_W-1:0] slot_vec(input logic [PRIO_W-1:0] p);
      return PRIO0_VEC + VEC_STEP * {{(VEC_W-PRIO_W){1'b0}}, p};
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   vim_state_t state_r, state_nxt;
   vec_req_t req_r, req_nxt;
   logic trap_r, trap_nxt;
   logic halted_r, halted_nxt;
   logic wake_r, wake_nxt;

   logic [NUM_PRIO-1:0] pend;
   logic any_pend;
   logic any_wake;
   logic [PRIO_W-1:0] win;

   // ----------------------------------------
   // fixed priority pick
   // ----------------------------------------
   always_comb begin
      pend = map_slots(src_i);
      any_pend = |pend;
      any_wake = |(pend & WAKE_MASK);
      win = '0;
      for (int i = NUM_PRIO - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win = PRIO_W'(i);
         end
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      req_nxt = req_r;
      trap_nxt = trap_r;
      halted_nxt = halted_r;
      wake_nxt = 1'b0;
      unique case (state_r)
         ST_RESET: begin
            // first fetch after reset is the start vector
            req_nxt.valid = 1'b1;
            req_nxt.prio = '0;
            req_nxt.addr = RESET_VEC;
            if (fetch_ack_i && req_r.valid) begin
               req_nxt.valid = 1'b0;
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // trap is unranked: it goes before any pending line
            if (trap_i) begin
               trap_nxt = 1'b1;
            end
            if (fetch_ack_i && req_r.valid) begin
               req_nxt.valid = 1'b0;
               if (trap_r) begin
                  trap_nxt = trap_i;
               end
            end else if (trap_r || trap_i) begin
               req_nxt.valid = 1'b1;
               req_nxt.prio = '0;
               req_nxt.addr = TRAP_VEC;
            end else begin
               // vector tracks the winner until the core takes it
               req_nxt.valid = any_pend;
               req_nxt.prio = win;
               req_nxt.addr = slot_vec(win);
            end
            if (halt_req_i && !(fetch_ack_i && req_r.valid)) begin
               state_nxt = ST_HALT;
               halted_nxt = 1'b1;
               req_nxt.valid = 1'b0;
            end
         end
         ST_HALT: begin
            // trap and non-waking lines stay masked while halted
            req_nxt.valid = 1'b0;
            if (any_wake) begin
               state_nxt = ST_RUN;
               halted_nxt = 1'b0;
               wake_nxt = 1'b1;
            end
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_RESET;
         req_r <= '0;
         trap_r <= 1'b0;
         halted_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         req_r <= req_nxt;
         trap_r <= trap_nxt;
         halted_r <= halted_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign req_o = req_r;
   assign trap_pend_o = trap_r;
   assign halted_o = halted_r;
   assign wake_o = wake_r;

endmodule

// >>> test/vim_checker.sv
// checker: port properties of the interrupt map
// assumes the ports of vectored_interrupt_map
`timescale 1ns/100ps
module vim_checker (
   // watched ports
   input wire logic clk_i,
   input wire logic rst_n_i,
   input vim_pkg::irq_src_t src_i,
   input wire logic fetch_ack_i,
   input vim_pkg::vec_req_t req_o,
   input wire logic trap_pend_o,
   input wire logic halted_o,
   input wire logic wake_o
);
   import vim_pkg::*;
   wire wake_src = src_i.auto_wake | (|src_i.port_ae) | src_i.spi_eot | src_i.i2c;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_reset_vec: assert property (
      !$past(rst_n_i) |=> req_o.valid && req_o.addr == RESET_VEC) else $error("no reset vector");
   a_vec_addr: assert property (
      req_o.valid && req_o.addr >= PRIO0_VEC |-> req_o.addr == PRIO0_VEC + {17'h0, req_o.prio, 2'h0})
      else $error("bad vector");
   a_no_resv: assert property (
      req_o.valid |-> !(req_o.prio inside {5'h08, 5'h09, 5'h11, 5'h12})) else $error("reserved slot");
   a_trap_first: assert property (
      trap_pend_o && req_o.valid && !fetch_ack_i |=> req_o.addr == TRAP_VEC) else $error("trap late");
   a_ack_drop: assert property (
      req_o.valid && fetch_ack_i |=> !req_o.valid) else $error("valid after ack");
   a_halt_quiet: assert property (
      halted_o |-> !req_o.valid) else $error("offer in halt");
   a_halt_hold: assert property (
      halted_o && !wake_src |=> halted_o) else $error("halt left");
   a_wake_exit: assert property (
      halted_o && wake_src |=> !halted_o && wake_o) else $error("no wake");
   a_wake_pulse: assert property (
      wake_o |-> $past(halted_o) ##1 !wake_o) else $error("wake pulse");
endmodule
bind vectored_interrupt_map vim_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_i(src_i),
   .fetch_ack_i(fetch_ack_i), .req_o(req_o), .trap_pend_o(trap_pend_o), .halted_o(halted_o),
   .wake_o(wake_o));

// >>> test/vim_core_model.sv
// core model: takes each offered vector after 0..3 wait cycles
// assumes req_i straight from the map
`timescale 1ns/100ps
module vim_core_model (
   // map side
   input wire logic clk_i,
   input wire logic rst_n_i,
   input vim_pkg::vec_req_t req_i,
   input wire logic [1:0] delay_i,
   output logic fetch_ack_o
);
   import vim_pkg::*;
   logic [1:0] wait_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 2'h0;
         fetch_ack_o <= 1'b0;
      end else begin
         // any vector returns harmlessly, so all are taken alike
         fetch_ack_o <= req_i.valid && !fetch_ack_o && wait_r == 2'h0;
         wait_r <= (!req_i.valid || fetch_ack_o) ? delay_i : wait_r - 2'(wait_r != 2'h0);
      end
   end
endmodule

// >>> test/tb.sv
// tb: random and halt traffic against a behavioural core
// assumes vim_pkg, the map and the core model
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
   import vim_pkg::*;
   logic clk_i = 0, rst_n_i = 0, trap_i = 0, halt_req_i = 0, ack, trap_pend, halted, wake;
   logic [1:0] dly = 0;
   irq_src_t src = '0, m;
   vec_req_t req;
   logic [VEC_W-1:0] ev, exp_q[$];
   int n_fail = 0, compares = 0, seed = 56396;
   int slot[22] = '{24, 24, 23, 22, 21, 20, 19, 16, 15, 14, 13, 12, 11, 10, 3, 4, 5, 6, 7, 2, 1, 0};
   int wb[8] = '{20, 18, 17, 16, 15, 14, 13, 6};
   int nb[4] = '{21, 19, 12, 0};
   vectored_interrupt_map u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_i(src), .trap_i(trap_i),
      .halt_req_i(halt_req_i), .fetch_ack_i(ack), .req_o(req), .trap_pend_o(trap_pend),
      .halted_o(halted), .wake_o(wake));
   vim_core_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .delay_i(dly),
      .fetch_ack_o(ack));
   initial forever #10 clk_i = ~clk_i;
   task conclude;
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task push_set(input irq_src_t s);
      s[1] = s[1] & !s[0];
      for (int q = 0; q < 25; q++)
         for (int b = 0; b < 22; b++)
            if (s[b] && slot[b] == q) exp_q.push_back(PRIO0_VEC + 24'(4 * q));
   endtask
   task wait_for(input int lim, input logic hl, input logic v);
      int i;
      for (i = 0; i < lim && (hl ? halted !== v : exp_q.size() != 0 || src != 0); i++)
         @(negedge clk_i);
      if (i == lim) begin
         n_fail++;
         conclude();
      end
   endtask
   always @(posedge clk_i) begin
      if (rst_n_i && req.valid && ack) begin
         ev = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
         `CHK("vector", ev, req.addr)
         for (int b = 0; b < 22; b++)
            if (req.addr == PRIO0_VEC + 24'(4 * slot[b])) src[b] <= 1'b0;
      end
   end
   initial begin
      exp_q.push_back(RESET_VEC);
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_for(300, 1'b0, 1'b0);
      repeat (40) begin
         @(posedge clk_i);
         dly <= 2'($random(seed));
         trap_i <= 1'b1;
         exp_q.push_back(TRAP_VEC);
         @(posedge clk_i);
         trap_i <= 1'b0;
         m = 22'($random(seed));
         push_set(m);
         src <= m;
         @(negedge clk_i);
         `CHK("trap_pend", 1'b1, trap_pend)
         wait_for(300, 1'b0, 1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         halt_req_i <= 1'b1;
         wait_for(20, 1'b1, 1'b1);
         @(posedge clk_i);
         halt_req_i <= 1'b0;
         m = '0;
         m[nb[i % 4]] = 1'b1;
         src <= m;
         repeat (4) @(negedge clk_i);
         `CHK("halted", 1'b1, halted)
         @(posedge clk_i);
         m[wb[i]] = 1'b1;
         push_set(m);
         src <= m;
         wait_for(20, 1'b1, 1'b0);
         `CHK("wake", 1'b1, wake)
         wait_for(300, 1'b0, 1'b0);
      end
      // reset taken while halted restarts from the start vector
      @(posedge clk_i);
      halt_req_i <= 1'b1;
      wait_for(20, 1'b1, 1'b1);
      @(posedge clk_i);
      halt_req_i <= 1'b0;
      rst_n_i <= 1'b0;
      exp_q.push_back(RESET_VEC);
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      `CHK("halted", 1'b0, halted)
      wait_for(300, 1'b0, 1'b0);
      conclude();
   end
endmodule
